// ==== pmcs_top.sv ====
// Power-mode clock selector: picks the device clock source and run, idle or
// sleep mode, gates CPU and peripheral clock enables, runs power-up timers.
// Assumes oscillator ticks arrive asynchronously and far slower than aclk.
//
// Behaviour
// - Primary oscillator runs only in primary modes
// - Secondary modes clock from secondary oscillator
// - Secondary oscillator may run in any mode
// - Internal modes clock from 31 kHz oscillator
// - Sleep stops clocks except those features need
// - Internal oscillator runs while watchdog enabled
// - Power-up timer holds reset, always on
// - Crystal waits 1024 oscillator cycles before clocking; after sleep peripherals are clocked from it during that wait
// - Ready interval before first instruction after reset
// - External clock: output pin low in sleep
// - Idle bit 7, select field bits 1:0
// - Select codes 10 primary, 01 secondary, 11 internal
// - Select write switches at once if running
// - Idle or sleep only on sleep instruction
// - Idle bit chooses sleep or idle
// - Switch: two old plus three new cycles
// - Status bits show primary or secondary clock
// - At most one status bit set
// - Idle bit sampled at each sleep instruction
// - Select field cleared on every reset
// - Code 00 follows default source bit
// - Secondary select ignored while oscillator disabled
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`include "pmcs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pmcs_top
   import pmcs_pkg::*;
#(
   parameter int POWERUP_CYCLES = (`PMCS_POWERUP_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core events, same clock
   input wire logic sleep_exec,
   input wire logic irq_wake,
   input wire logic wdt_wake,
   // Raw oscillator outputs, asynchronous
   input wire logic pri_osc_clk,
   input wire logic sec_osc_clk,
   input wire logic int_osc_clk,
   // Oscillator enables
   output logic pri_osc_en,
   output logic sec_osc_en,
   output logic int_osc_en,
   // Gated clock enables and core reset
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic core_reset_n,
   // Clock divided by four on the oscillator output pin
   output logic osc_output_pin
);

   // Ready interval in aclk cycles, rounded up
   localparam int READY_CYCLES = (`PMCS_READY_NS + `PMCS_CLK_PERIOD_NS - 1) / `PMCS_CLK_PERIOD_NS;
   // Configuration reset word, so single bits can be picked out of it
   localparam logic [2:0] CFG_RST = `PMCS_CFG_RST;

   // Refuse a power-up count below one cycle
   if (POWERUP_CYCLES < 1) begin : g_chk
      $error("POWERUP_CYCLES must be at least 1");
   end

   // Software-visible control bits
   logic idle_en_r;
   logic [1:0] sel_field_r;
   logic sec_osc_en_r;
   logic def_src_r;
   logic crystal_r;
   logic wdt_en_r;

   // Sequencer state and source tracking
   pmcs_state_e state_r;
   pmcs_src_e cur_src_r;
   pmcs_src_e new_src_r;
   pmcs_src_e target;
   pmcs_src_e decoded;

   // Counters
   logic [31:0] pup_cnt_r;
   logic pup_done_r;
   logic [15:0] rdy_cnt_r;
   logic [1:0] tick_cnt_r;
   logic [10:0] start_cnt_r;
   logic start_done_r;
   logic sec_seen_r;
   logic [1:0] div_r;

   // Synchroniser chain and edge detect for the three oscillators
   logic [2:0] osc_s1_r;
   logic [2:0] osc_s2_r;
   logic [2:0] osc_s3_r;
   logic pri_tick;
   logic sec_tick;
   logic int_tick;
   logic cur_tick;
   logic new_tick;

   // Source readiness and status
   logic pri_ready;
   logic sec_ready;
   logic tgt_ready;
   logic startup_done;
   logic sec_running;

   // Bus holding registers
   logic aw_got_r;
   logic w_got_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;
   logic rd_fire;
   logic wr_hit;

   // Two flops before any logic, third flop only for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_s1_r <= 3'h0;
         osc_s2_r <= 3'h0;
         osc_s3_r <= 3'h0;
      end else begin
         osc_s1_r <= {int_osc_clk, sec_osc_clk, pri_osc_clk};
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end

   // One-cycle pulse per rising oscillator edge
   assign pri_tick = osc_s2_r[0] & ~osc_s3_r[0];
   assign sec_tick = osc_s2_r[1] & ~osc_s3_r[1];
   assign int_tick = osc_s2_r[2] & ~osc_s3_r[2];

   // Tick of a given source
   function automatic logic src_tick(input pmcs_src_e s, input logic p, input logic c, input logic i);
      case (s)
         PMCS_SRC_PRI: src_tick = p;
         PMCS_SRC_SEC: src_tick = c;
         default: src_tick = i;
      endcase
   endfunction

   always_comb begin
      case (sel_field_r)
         2'h1: decoded = PMCS_SRC_SEC;
         2'h2: decoded = PMCS_SRC_PRI;
         2'h3: decoded = PMCS_SRC_INT;
         default: decoded = def_src_r ? PMCS_SRC_PRI : PMCS_SRC_INT;
      endcase
   end

   assign target = (decoded == PMCS_SRC_SEC && !sec_osc_en_r) ? cur_src_r : decoded;

   assign pri_ready = crystal_r ? start_done_r : pri_osc_en;
   assign sec_ready = sec_osc_en_r & sec_seen_r;
   always_comb begin
      case (target)
         PMCS_SRC_PRI: tgt_ready = pri_ready;
         PMCS_SRC_SEC: tgt_ready = sec_ready;
         default: tgt_ready = 1'b1;
      endcase
   end

   assign cur_tick = src_tick(cur_src_r, pri_tick, sec_tick, int_tick);
   assign new_tick = src_tick(new_src_r, pri_tick, sec_tick, int_tick);

   // power-up timer, no way to disable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pup_cnt_r <= 32'h0;
         pup_done_r <= 1'b0;
      end else if (!pup_done_r) begin
         pup_cnt_r <= pup_cnt_r + 32'h1;
         pup_done_r <= (pup_cnt_r == 32'(POWERUP_CYCLES - 1));
      end
   end

   // start-up timer counts primary edges, restarts when oscillator stops
   always_ff @(posedge aclk) begin
      if (!aresetn || !pri_osc_en) begin
         start_cnt_r <= 11'h0;
         start_done_r <= 1'b0;
      end else if (pri_tick && !start_done_r) begin
         start_cnt_r <= start_cnt_r + 11'h1;
         start_done_r <= (start_cnt_r == 11'(`PMCS_STARTUP_CYCLES - 1));
      end
   end

   // Secondary counts as running once an edge is seen after enabling
   always_ff @(posedge aclk) begin
      if (!aresetn || !sec_osc_en_r) begin
         sec_seen_r <= 1'b0;
      end else if (sec_tick) begin
         sec_seen_r <= 1'b1;
      end
   end

   // Power-mode sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= PMCS_ST_BOOT;
         cur_src_r <= PMCS_SRC_INT;
         new_src_r <= PMCS_SRC_INT;
         tick_cnt_r <= 2'h0;
         rdy_cnt_r <= 16'h0;
      end else begin
         case (state_r)
            // Internal oscillator clocks until power-up and start-up are over
            PMCS_ST_BOOT: begin
               if (pup_done_r && tgt_ready) begin
                  cur_src_r <= target;
                  rdy_cnt_r <= 16'h0;
                  state_r <= PMCS_ST_WAKE;
               end
            end
            PMCS_ST_WAKE: begin
               if (rdy_cnt_r != 16'(READY_CYCLES)) begin
                  rdy_cnt_r <= rdy_cnt_r + 16'h1;
               end else if (tgt_ready) begin
                  cur_src_r <= target;
                  state_r <= PMCS_ST_RUN;
               end
            end
            PMCS_ST_RUN: begin
               // low power only on sleep instruction
               // bit taken as it stands now
               if (sleep_exec) begin
                  state_r <= idle_en_r ? PMCS_ST_IDLE : PMCS_ST_SLEEP;
               end else if (target != cur_src_r && tgt_ready) begin
                  new_src_r <= target;
                  tick_cnt_r <= 2'h0;
                  state_r <= PMCS_ST_SW_OLD;
               end
            end
            PMCS_ST_SW_OLD: begin
               if (cur_tick) begin
                  if (tick_cnt_r == 2'(`PMCS_SWITCH_OLD_TICKS - 1)) begin
                     tick_cnt_r <= 2'h0;
                     state_r <= PMCS_ST_SW_NEW;
                  end else begin
                     tick_cnt_r <= tick_cnt_r + 2'h1;
                  end
               end
            end
            PMCS_ST_SW_NEW: begin
               if (new_tick) begin
                  if (tick_cnt_r == 2'(`PMCS_SWITCH_NEW_TICKS - 1)) begin
                     cur_src_r <= new_src_r;
                     state_r <= PMCS_ST_RUN;
                  end else begin
                     tick_cnt_r <= tick_cnt_r + 2'h1;
                  end
               end
            end
            PMCS_ST_IDLE, PMCS_ST_SLEEP: begin
               if (irq_wake || wdt_wake) begin
                  rdy_cnt_r <= 16'h0;
                  state_r <= PMCS_ST_WAKE;
               end
            end
            default: begin
               state_r <= PMCS_ST_BOOT;
            end
         endcase
      end
   end

   // Oscillator enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pri_osc_en <= 1'b0;
         sec_osc_en <= 1'b0;
         int_osc_en <= 1'b1;
      end else begin
         pri_osc_en <= (state_r != PMCS_ST_SLEEP) &&
            ((cur_src_r == PMCS_SRC_PRI && state_r != PMCS_ST_BOOT) ||
             (target == PMCS_SRC_PRI && state_r != PMCS_ST_IDLE && (state_r != PMCS_ST_BOOT || pup_done_r)));
         // free to run in any mode
         sec_osc_en <= sec_osc_en_r;
         int_osc_en <= wdt_en_r || state_r == PMCS_ST_BOOT ||
            (state_r != PMCS_ST_SLEEP && (cur_src_r == PMCS_SRC_INT || target == PMCS_SRC_INT));
      end
   end

   assign cpu_clk_en = (state_r == PMCS_ST_RUN) && cur_tick;
   assign periph_clk_en = (state_r == PMCS_ST_RUN || state_r == PMCS_ST_IDLE ||
                           state_r == PMCS_ST_WAKE) && cur_tick;

   // Core held in reset during power-up and start-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_reset_n <= 1'b0;
      end else begin
         core_reset_n <= (state_r != PMCS_ST_BOOT);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 2'h0;
         osc_output_pin <= 1'b0;
      end else begin
         if (pri_tick) begin
            div_r <= div_r + 2'h1;
         end
         osc_output_pin <= !crystal_r && state_r != PMCS_ST_SLEEP && div_r[1];
      end
   end

   // one bit at most, none in sleep
   assign startup_done = cur_src_r == PMCS_SRC_PRI && pri_ready &&
                         state_r != PMCS_ST_SLEEP && state_r != PMCS_ST_BOOT;
   assign sec_running = cur_src_r == PMCS_SRC_SEC &&
                        state_r != PMCS_ST_SLEEP && state_r != PMCS_ST_BOOT;

   // Write channels taken independently, response after both
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready = !w_got_r && !s_axi_bvalid;
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   assign wr_hit = (aw_addr_r == `PMCS_OFS_OSC_CTRL) || (aw_addr_r == `PMCS_OFS_TMR1_CTRL) ||
                   (aw_addr_r == `PMCS_OFS_CONFIG) || (aw_addr_r == `PMCS_OFS_MODE);

   // Write address and data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 8'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
         end else if (wr_fire) begin
            aw_got_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_got_r <= 1'b0;
         end
      end
   end

   // Write response, unmapped offsets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMCS_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `PMCS_RESP_OKAY : `PMCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register writes through byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_en_r <= 1'b0;
         sel_field_r <= `PMCS_SEL_RST;
         sec_osc_en_r <= 1'b0;
         def_src_r <= CFG_RST[`PMCS_BIT_DEF_SRC];
         crystal_r <= CFG_RST[`PMCS_BIT_CRYSTAL];
         wdt_en_r <= CFG_RST[`PMCS_BIT_WDT_EN];
      end else if (wr_fire && w_strb_r[0]) begin
         case (aw_addr_r)
            `PMCS_OFS_OSC_CTRL: begin
               idle_en_r <= w_data_r[`PMCS_BIT_IDLE_EN];
               sel_field_r <= w_data_r[`PMCS_SEL_HI:`PMCS_SEL_LO];
            end
            `PMCS_OFS_TMR1_CTRL: begin
               sec_osc_en_r <= w_data_r[`PMCS_BIT_SEC_OSC_EN];
            end
            `PMCS_OFS_CONFIG: begin
               def_src_r <= w_data_r[`PMCS_BIT_DEF_SRC];
               crystal_r <= w_data_r[`PMCS_BIT_CRYSTAL];
               wdt_en_r <= w_data_r[`PMCS_BIT_WDT_EN];
            end
            default: begin
               idle_en_r <= idle_en_r;
            end
         endcase
      end
   end

   // Read channel, one beat at a time
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // Read data mux with status bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `PMCS_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `PMCS_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         case ({s_axi_araddr[7:2], 2'h0})
            `PMCS_OFS_OSC_CTRL: begin
               s_axi_rdata[`PMCS_BIT_IDLE_EN] <= idle_en_r;
               s_axi_rdata[`PMCS_BIT_STARTUP_DONE] <= startup_done;
               s_axi_rdata[`PMCS_SEL_HI:`PMCS_SEL_LO] <= sel_field_r;
            end
            `PMCS_OFS_TMR1_CTRL: begin
               s_axi_rdata[`PMCS_BIT_SEC_RUNNING] <= sec_running;
               s_axi_rdata[`PMCS_BIT_SEC_OSC_EN] <= sec_osc_en_r;
            end
            `PMCS_OFS_CONFIG: begin
               s_axi_rdata[`PMCS_BIT_DEF_SRC] <= def_src_r;
               s_axi_rdata[`PMCS_BIT_CRYSTAL] <= crystal_r;
               s_axi_rdata[`PMCS_BIT_WDT_EN] <= wdt_en_r;
            end
            `PMCS_OFS_MODE: begin
               s_axi_rdata[4:0] <= {cur_src_r, state_r};
            end
            default: begin
               s_axi_rresp <= `PMCS_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== pmcs_defines.svh ====
// Constants of the power-mode clock selector: register offsets, bit positions,
// reset values and timing figures. Assumes a 100 MHz system clock.
`ifndef PMCS_DEFINES_SVH
`define PMCS_DEFINES_SVH

// Register byte offsets on the AXI4-Lite port
`define PMCS_OFS_OSC_CTRL 8'h00
`define PMCS_OFS_TMR1_CTRL 8'h04
`define PMCS_OFS_CONFIG 8'h08
`define PMCS_OFS_MODE 8'h0C

// Oscillator control register fields
`define PMCS_BIT_IDLE_EN 7
`define PMCS_BIT_STARTUP_DONE 3
`define PMCS_SEL_HI 1
`define PMCS_SEL_LO 0

// Timer one control register fields
`define PMCS_BIT_SEC_RUNNING 6
`define PMCS_BIT_SEC_OSC_EN 3

// Configuration register fields
`define PMCS_BIT_DEF_SRC 0
`define PMCS_BIT_CRYSTAL 1
`define PMCS_BIT_WDT_EN 2

// Reset values
`define PMCS_SEL_RST 2'h0
`define PMCS_CFG_RST 3'h3

// Timing
`define PMCS_CLK_PERIOD_NS 10
`define PMCS_STARTUP_CYCLES 1024
`define PMCS_SWITCH_OLD_TICKS 2
`define PMCS_SWITCH_NEW_TICKS 3
`define PMCS_POWERUP_NS 1000000
`define PMCS_READY_NS 2000

// Bus responses
`define PMCS_RESP_OKAY 2'h0
`define PMCS_RESP_SLVERR 2'h2

`endif

// ==== pmcs_pkg.sv ====
// Types of the power-mode clock selector.
// Assumes the constants header is compiled alongside.
package pmcs_pkg;

   // Clock source, encoded as the source-select field
   typedef enum logic [1:0] {
      PMCS_SRC_DEF = 2'h0,
      PMCS_SRC_SEC = 2'h1,
      PMCS_SRC_PRI = 2'h2,
      PMCS_SRC_INT = 2'h3
   } pmcs_src_e;

   // Power-mode sequencer states, Gray coded along boot, wake, run, switch
   typedef enum logic [2:0] {
      PMCS_ST_BOOT = 3'h0,
      PMCS_ST_WAKE = 3'h1,
      PMCS_ST_RUN = 3'h3,
      PMCS_ST_SW_OLD = 3'h2,
      PMCS_ST_SW_NEW = 3'h6,
      PMCS_ST_IDLE = 3'h7,
      PMCS_ST_SLEEP = 3'h5
   } pmcs_state_e;

endpackage

// ==== pmcs_props.sv ====
// Checker for the power-mode clock selector: bus handshakes and clock gating.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pmcs_props (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Clock enables and core reset
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic core_reset_n
);
   // All checks run on the bus clock
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Write answer stays until taken
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   // Read answer stays until taken
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // Read answer closes once taken, no second beat
   read_close_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   // No new write while response pending
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   // Write answered within two cycles
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
      ##[1:2] s_axi_bvalid)
      else $error("write response late");
   // Read answered next cycle
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   // CPU clock only as single pulses
   cpu_pulse_a: assert property (cpu_clk_en |=> !cpu_clk_en)
      else $error("cpu clock pulse widened");
   // Peripheral clock only as single pulses
   periph_pulse_a: assert property (periph_clk_en |=> !periph_clk_en)
      else $error("peripheral clock pulse widened");
   // CPU clocked implies peripherals clocked
   cpu_periph_a: assert property (cpu_clk_en |-> periph_clk_en)
      else $error("cpu clocked without peripherals");
   // No CPU clock while core held
   core_hold_a: assert property (!core_reset_n |-> !cpu_clk_en)
      else $error("cpu clocked in reset");
   // Core never re-enters reset on its own
   core_fall_a: assert property ($past(aresetn) |-> !$fell(core_reset_n))
      else $error("core reset asserted in run");
endmodule

bind pmcs_top pmcs_props chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_clk_en, .periph_clk_en, .core_reset_n);
`default_nettype wire

// ==== power_mode_clock_selector_tb.sv ====
// Self-checking bench for the power-mode clock selector through its register port.
// Assumes the defines header and package are compiled first.
`include "pmcs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_selector_tb;
   // Register offsets and shortened power-up count
   localparam logic [7:0] OSC = `PMCS_OFS_OSC_CTRL;
   localparam logic [7:0] TMR = `PMCS_OFS_TMR1_CTRL;
   localparam logic [7:0] CFG = `PMCS_OFS_CONFIG;
   localparam logic [7:0] MODE = `PMCS_OFS_MODE;
   localparam logic [1:0] OK = `PMCS_RESP_OKAY;
   localparam int PWR = 20;
   // Design inputs
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic sleep_exec = 1'b0, irq_wake = 1'b0, wdt_wake = 1'b0;
   logic pri_clk = 1'b0, sec_clk = 1'b0, int_clk = 1'b0;
   // Design outputs
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic pri_en, sec_en, int_en, cpu_en, per_en, core_rst_n, pin;
   // Bench state
   logic [11:0] div = 12'h000;
   int errors = 0, n_checks = 0, cyc = 0, ncpu, nper, npin;

   pmcs_top #(.POWERUP_CYCLES(PWR)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep_exec(sleep_exec), .irq_wake(irq_wake), .wdt_wake(wdt_wake),
      .pri_osc_clk(pri_clk), .sec_osc_clk(sec_clk), .int_osc_clk(int_clk),
      .pri_osc_en(pri_en), .sec_osc_en(sec_en), .int_osc_en(int_en), .cpu_clk_en(cpu_en),
      .periph_clk_en(per_en), .core_reset_n(core_rst_n), .osc_output_pin(pin));

   // 100 MHz bus clock
   initial forever #5 aclk = ~aclk;

   // Oscillators run only while enabled, periods 8, 16 and 32 cycles
   always @(posedge aclk) begin
      div <= div + 12'h001;
      pri_clk <= pri_en & div[2];
      sec_clk <= sec_en & div[3];
      int_clk <= int_en & div[4];
   end

   // Hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         complete_run();
      end
   end

   // Compare one value and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
   endtask

   // Bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, e});
   endtask

   // Bus read into d and r
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Read and compare, response must be OKAY
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
      chk({30'h0, r}, {30'h0, OK});
   endtask

   // Poll the mode register until it shows e
   task automatic wmode(input logic [31:0] e);
      rd(MODE);
      for (int i = 0; i < 4000 && d !== e; i++) rd(MODE);
      chk(d, e);
   endtask

   // One-cycle core event: 0 sleep, 1 interrupt, 2 watchdog
   task automatic pulse(input int k);
      @(posedge aclk);
      sleep_exec <= (k == 0);
      irq_wake <= (k == 1);
      wdt_wake <= (k == 2);
      @(posedge aclk);
      sleep_exec <= 1'b0;
      irq_wake <= 1'b0;
      wdt_wake <= 1'b0;
   endtask

   // Count clock pulses and pin highs over a window
   task automatic win();
      ncpu = 0;
      nper = 0;
      npin = 0;
      repeat (128) begin
         @(posedge aclk);
         ncpu += cpu_en;
         nper += per_en;
         npin += pin;
      end
   endtask

   // Verdict and end of run
   task automatic complete_run();
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (100) @(posedge aclk);
      chk({31'h0, core_rst_n}, 32'h0);
      for (int i = 0; i < 20000 && core_rst_n !== 1'b1; i++) @(posedge aclk);
      chk({31'h0, cyc >= PWR + (`PMCS_STARTUP_CYCLES - 1) * 8}, 32'h1);
      rc(MODE, 32'h11);
      rc(OSC, 32'h08);
      rc(TMR, 32'h00);
      rc(CFG, 32'h03);
      wmode(32'h13);
      rd(8'h10);
      chk({30'h0, r}, {30'h0, `PMCS_RESP_SLVERR});
      wr(8'h10, 32'hFF, `PMCS_RESP_SLVERR);
      // Secondary refused while its oscillator is off
      wr(OSC, 32'h01, OK);
      repeat (300) @(posedge aclk);
      rc(MODE, 32'h13);
      wr(TMR, 32'h08, OK);
      wr(OSC, 32'h01, OK);
      wmode(32'h0B);
      rc(OSC, 32'h01);
      rc(TMR, 32'h48);
      chk({31'h0, pri_en}, 32'h0);
      wr(OSC, 32'h03, OK);
      wmode(32'h1B);
      rc(TMR, 32'h08);
      // Sleep stops everything but the secondary
      pulse(0);
      rd(MODE);
      chk({29'h0, d[2:0]}, 32'h5);
      chk({29'h0, pri_en, sec_en, int_en}, 32'h2);
      win();
      chk(ncpu + nper, 32'h0);
      pulse(1);
      wmode(32'h1B);
      // Idle bit alone changes nothing until sleep
      wr(OSC, 32'h83, OK);
      rc(MODE, 32'h1B);
      pulse(0);
      rd(MODE);
      chk({29'h0, d[2:0]}, 32'h7);
      win();
      chk(ncpu, 32'h0);
      chk({31'h0, nper > 0}, 32'h1);
      pulse(2);
      wmode(32'h1B);
      wr(OSC, 32'h03, OK);
      pulse(0);
      rd(MODE);
      chk({29'h0, d[2:0]}, 32'h5);
      pulse(1);
      wmode(32'h1B);
      // Code 00 follows the default-source bit
      wr(OSC, 32'h00, OK);
      wmode(32'h13);
      rc(OSC, 32'h08);
      wr(CFG, 32'h02, OK);
      wmode(32'h1B);
      // External clock with watchdog on
      wr(CFG, 32'h05, OK);
      wmode(32'h13);
      wr(OSC, 32'h02, OK);
      rc(MODE, 32'h13);
      win();
      chk({31'h0, npin > 0}, 32'h1);
      pulse(0);
      @(posedge aclk);
      win();
      chk(npin, 32'h0);
      chk({31'h0, int_en}, 32'h1);
      pulse(1);
      wmode(32'h13);
      complete_run();
   end
endmodule
`default_nettype wire
